// ===== rtl/gpb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module gpb_bank
  import gpb_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave, byte address
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [DATA_W/8-1:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  // Pads: bit 8*port+x, port A=0, B=1, C=2
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic [NPIN-1:0] pin_pullup,
  // Peripheral alternate functions
  input wire logic [NPIN-1:0] alt_oe,
  input wire logic [NPIN-1:0] alt_out,
  output logic [NPIN-1:0] alt_in,
  // Core interface
  input wire logic core_int_masked,
  input wire logic [NVEC-1:0] vec_fetch,
  output logic [NVEC-1:0] ext_irq,
  output logic wake,
  // Software-visible interrupt line
  output logic irq
);
  // Elaboration checks: the byte map needs 32-bit words and 8 address bits
  if (DATA_W != 32) begin : g_bad_data_w
    $error("gpb_bank needs 32-bit data");
  end
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("gpb_bank needs at least 8 address bits");
  end

  // Register storage: one byte per port for latch, direction and option; interrupt state per vector
  logic [NPORT-1:0][PORT_W-1:0] latch_q; // Data latches
  logic [NPORT-1:0][PORT_W-1:0] dir_q; // Direction registers
  logic [NPORT-1:0][PORT_W-1:0] opt_q; // Option registers
  logic [NVEC-1:0] stat_q; // Sticky event status
  logic [NVEC-1:0] en_q; // Status enables
  logic [NVEC-1:0] req_q; // Vector request latches
  logic [NPIN-1:0] prev_q; // Previous synchronised level

  // Bus handshake state
  logic waitrequest_q; // Registered waitrequest
  logic [DATA_W-1:0] readdata_q; // Registered read data
  logic [5:0] idx; // Word index
  logic req_any; // Any request on bus
  logic wr_do; // Write takes effect this edge
  logic [7:0] wbyte; // Low byte of write data
  logic [7:0] rd_d; // Read mux result

  // Per-pin decoded values
  logic [NPIN-1:0] pin_sync; // Synchronised pin levels
  logic [NPIN-1:0] dir_v; // Flat direction
  logic [NPIN-1:0] opt_v; // Flat option
  logic [NPIN-1:0] latch_v; // Flat latch
  logic [NPIN-1:0] out_d; // Next pad value
  logic [NPIN-1:0] oe_d; // Next pad enable
  logic [NPIN-1:0] pu_d; // Next pull-up
  logic [NPIN-1:0] rd_v; // Read-back bits
  logic [NPIN-1:0] alt_in_d; // Next peripheral input
  logic [NPIN-1:0] int_en; // Interrupt-capable pins
  logic [NPIN-1:0] fall; // Falling edge per pin
  logic [NVEC-1:0] evt; // Combined event per vector

  // Pin levels are synchronised before any use
  gpb_sync #(
    .W(NPIN)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Flatten the per-port registers, bit x of port p is pin 8p+x
  assign dir_v = dir_q;
  assign opt_v = opt_q;
  assign latch_v = latch_q;

  // One decode cell per pin
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      gpb_pin_cell u_cell (
        .dir(dir_v[g]),
        .opt(opt_v[g]),
        .latch(latch_v[g]),
        .tod(TOD_MASK[g]),
        .alt_oe(alt_oe[g]),
        .alt_out(alt_out[g]),
        .pin_lvl(pin_sync[g]),
        .out_d(out_d[g]),
        .oe_d(oe_d[g]),
        .pu_d(pu_d[g]),
        .rd_bit(rd_v[g]),
        .alt_in(alt_in_d[g]),
        .int_en(int_en[g])
      );
    end
  endgenerate

  // Bus decode helpers
  assign idx = address[7:2];
  assign req_any = read || write;
  assign wr_do = write && !waitrequest_q;
  assign wbyte = writedata[7:0];

  // Read multiplexer, offsets per port
  always_comb begin
    unique case (idx)
      IDX_PC_DATA: rd_d = rd_v[PC*PORT_W +: PORT_W];
      IDX_PC_DIR: rd_d = dir_q[PC];
      IDX_PC_OPT: rd_d = opt_q[PC];
      IDX_PB_DATA: rd_d = rd_v[PB*PORT_W +: PORT_W];
      IDX_PB_DIR: rd_d = dir_q[PB];
      IDX_PB_OPT: rd_d = opt_q[PB];
      IDX_PA_DATA: rd_d = rd_v[PA*PORT_W +: PORT_W];
      IDX_PA_DIR: rd_d = dir_q[PA];
      IDX_PA_OPT: rd_d = opt_q[PA];
      IDX_IRQ_STATUS: rd_d = {6'h00, stat_q};
      IDX_IRQ_ENABLE: rd_d = {6'h00, en_q};
      // Clear register and unmapped space read zero
      default: rd_d = 8'h00;
    endcase
  end

  // Waitrequest: one cycle of wait, then one cycle low per access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest_q <= 1'b1;
    end else if (req_any && waitrequest_q) begin
      // Request seen: answer next cycle
      waitrequest_q <= 1'b0;
    end else begin
      // Accepted or idle: back to waiting
      waitrequest_q <= 1'b1;
    end
  end

  // Read data captured as waitrequest falls, held otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata_q <= '0;
    end else if (read && waitrequest_q) begin
      readdata_q <= {24'h000000, rd_d};
    end
  end

  // Data latches: written whatever the direction
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_q <= '0;
    end else if (wr_do && byteenable[0]) begin
      unique case (idx)
        IDX_PC_DATA: latch_q[PC] <= wbyte;
        IDX_PB_DATA: latch_q[PB] <= wbyte;
        IDX_PA_DATA: latch_q[PA] <= wbyte;
        default: begin
          // Other addresses leave latches alone
        end
      endcase
    end
  end

  // Direction registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_q <= '0;
    end else if (wr_do && byteenable[0]) begin
      unique case (idx)
        IDX_PC_DIR: dir_q[PC] <= wbyte;
        IDX_PB_DIR: dir_q[PB] <= wbyte;
        IDX_PA_DIR: dir_q[PA] <= wbyte;
        default: begin
          // Other addresses leave directions alone
        end
      endcase
    end
  end

  // Option registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opt_q <= '0;
    end else if (wr_do && byteenable[0]) begin
      unique case (idx)
        IDX_PC_OPT: opt_q[PC] <= wbyte;
        IDX_PB_OPT: opt_q[PB] <= wbyte;
        IDX_PA_OPT: opt_q[PA] <= wbyte;
        default: begin
          // Other addresses leave options alone
        end
      endcase
    end
  end

  // Falling-edge event on interrupt-enabled pins
  assign fall = prev_q & ~pin_sync & int_en;

  // Pins sharing a vector are OR-combined
  assign evt[0] = |(fall & VEC0_MASK);
  assign evt[1] = |(fall & VEC1_MASK);

  // Previous synchronised level for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= pin_sync;
    end
  end

  // Vector request latches: set by event, cleared by fetch, set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_q <= '0;
    end else begin
      req_q <= (req_q & ~vec_fetch) | evt;
    end
  end

  // Core requests gated by the core mask; wake is ungated
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_irq <= '0;
      wake <= 1'b0;
    end else begin
      ext_irq <= core_int_masked ? '0 : (req_q & ~vec_fetch);
      wake <= |req_q;
    end
  end

  // Sticky status: event sets, write-one clears, set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q <= IRQ_RESET;
    end else if (wr_do && byteenable[0] && idx == IDX_IRQ_CLEAR) begin
      stat_q <= (stat_q & ~wbyte[NVEC-1:0]) | evt;
    end else begin
      stat_q <= stat_q | evt;
    end
  end

  // Status enable register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_q <= IRQ_RESET;
    end else if (wr_do && byteenable[0] && idx == IDX_IRQ_ENABLE) begin
      en_q <= wbyte[NVEC-1:0];
    end
  end

  // Level interrupt while an enabled status bit is set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & en_q);
    end
  end

  // Pad and peripheral outputs registered, cleared by reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup <= '0;
      alt_in <= '0;
    end else begin
      pin_out <= out_d;
      pin_oe <= oe_d;
      pin_pullup <= pu_d;
      alt_in <= alt_in_d;
    end
  end

  // Bus outputs straight from flops
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
endmodule
`default_nettype wire

// ===== rtl/gpb_pkg.sv
package gpb_pkg;
  // Bank geometry
  localparam int PORT_W = 8;
  localparam int NPORT = 3;
  localparam int NPIN = PORT_W * NPORT;
  // Port slots inside the pin vectors
  localparam int PA = 0;
  localparam int PB = 1;
  localparam int PC = 2;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_PC_DATA = 6'h00;
  localparam logic [5:0] IDX_PC_DIR = 6'h01;
  localparam logic [5:0] IDX_PC_OPT = 6'h02;
  localparam logic [5:0] IDX_PB_DATA = 6'h04;
  localparam logic [5:0] IDX_PB_DIR = 6'h05;
  localparam logic [5:0] IDX_PB_OPT = 6'h06;
  localparam logic [5:0] IDX_PA_DATA = 6'h08;
  localparam logic [5:0] IDX_PA_DIR = 6'h09;
  localparam logic [5:0] IDX_PA_OPT = 6'h0a;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h11;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h12;
  // Reset values
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Pins A6 and A4 are true open-drain pads
  localparam logic [NPIN-1:0] TOD_MASK = 24'h000050;
  // External interrupt vector membership: ei0 port A, ei1 ports B and C
  localparam logic [NPIN-1:0] VEC0_MASK = 24'h0000ff;
  localparam logic [NPIN-1:0] VEC1_MASK = 24'hffff00;
  localparam int NVEC = 2;
  // Status bit positions
  localparam int ST_EI0 = 0;
  localparam int ST_EI1 = 1;
endpackage

// ===== rtl/gpb_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage level synchroniser for asynchronous pin inputs
module gpb_sync #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // First stage, read only by second stage

  // Two flops in series
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/gpb_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// Per-pin mode decode: drive, pull-up, read-back and alternate routing
module gpb_pin_cell (
  input wire logic dir, // 1 output, 0 input
  input wire logic opt, // Option bit
  input wire logic latch, // Stored data bit
  input wire logic tod, // True open-drain pad
  input wire logic alt_oe, // Peripheral drives this pin
  input wire logic alt_out, // Peripheral output value
  input wire logic pin_lvl, // Synchronised pin level
  output logic out_d, // Pad output value
  output logic oe_d, // Pad output enable
  output logic pu_d, // Pull-up enable
  output logic rd_bit, // Data register read value
  output logic alt_in, // Value seen by peripheral
  output logic int_en // Pin is an interrupt input
);
  logic src; // Selected drive source
  logic pp; // Push-pull drive selected

  // Drive and read decode
  always_comb begin
    // Peripheral output overrides direction and data
    src = alt_oe ? alt_out : latch;
    // Push-pull only on standard pads, with option set or when the peripheral drives
    pp = alt_oe ? !tod : (opt && !tod);
    out_d = 1'b0;
    oe_d = 1'b0;
    if (dir || alt_oe) begin
      if (pp) begin
        // Push-pull: both levels driven
        out_d = src;
        oe_d = 1'b1;
      end else begin
        // Open-drain: drive low only, high floats
        out_d = 1'b0;
        oe_d = !src;
      end
    end
    // Pull-up only on standard pads in input mode with option set
    pu_d = !dir && !alt_oe && opt && !tod;
    // Read-back selection
    if (dir) begin
      rd_bit = latch;
    end else if (alt_oe) begin
      rd_bit = alt_out;
    end else begin
      rd_bit = pin_lvl;
    end
    // Peripheral input sees latch when pin is an output
    alt_in = dir ? latch : pin_lvl;
    // Interrupt input: input mode with option set, both pad kinds
    int_en = !dir && opt;
  end
endmodule
`default_nettype wire

// ===== bench/gpb_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level relations of the bank: bus answer, pads, interrupts
module gpb_bank_properties
  import gpb_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_pullup,
  input wire logic [NPIN-1:0] alt_oe,
  input wire logic [NPIN-1:0] alt_out,
  input wire logic core_int_masked,
  input wire logic [NVEC-1:0] vec_fetch,
  input wire logic [NVEC-1:0] ext_irq,
  input wire logic wake,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A request seen with waitrequest high is answered next cycle
  chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer missing");
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  // Open-drain pads never pull up and never drive high
  chk_tod_pullup: assert property ((pin_pullup & TOD_MASK) == '0)
    else $error("pull-up on open-drain pad");
  chk_tod_high: assert property ((pin_oe & pin_out & TOD_MASK) == '0)
    else $error("open-drain pad driven high");
  // Peripheral output takes the standard pad one cycle later
  chk_alt_force: assert property ($past(alt_oe[8]) |-> pin_oe[8] && pin_out[8] == $past(alt_out[8]))
    else $error("peripheral drive lost");
  // Masked core sees no request
  chk_mask_gate: assert property (core_int_masked && $past(core_int_masked) |-> ext_irq == '0)
    else $error("request while masked");
  chk_wake_req: assert property (ext_irq != '0 |-> wake)
    else $error("request without wake");
  // Registered request drops on the edge after the fetch is seen
  chk_fetch_drop: assert property (vec_fetch[1] |=> !ext_irq[1])
    else $error("request after fetch");
  cover property (read && !waitrequest);
  cover property ($rose(ext_irq[1]));
  cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== bench/gpb_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pads and far-side drivers seen by the bank
module gpb_pad_model
  import gpb_pkg::*;
(
  input wire logic clock,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_pullup,
  input wire logic [NPIN-1:0] ext_en,
  input wire logic [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pin_in
);
  logic [NPIN-1:0] float_q = '0; // Level of a pad nobody holds
  // Undriven, unpulled pads change every cycle
  always @(posedge clock) begin
    float_q <= ~float_q;
  end
  // Bank drive wins, then far side, then pull-up, else wander
  assign pin_in = (pin_oe & pin_out) |
    (~pin_oe & ((ext_en & ext_val) | (~ext_en & (pin_pullup | float_q))));
endmodule
`default_nettype wire

// ===== bench/gpio_three_port_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Register-level bench for the three-port bank
module gpio_three_port_bank_tb
  import gpb_pkg::*;
;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [7:0] address = 8'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata, q;
  logic waitrequest, wake, irq, core_int_masked = 1'h0;
  logic [23:0] pin_in, pin_out, pin_oe, pin_pullup, alt_in;
  logic [23:0] alt_oe = '0, alt_out = '0, ext_en = '1, ext_val = '0;
  logic [1:0] vec_fetch = 2'h0, ext_irq;
  logic [7:0] adr [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28};
  int bad_count = 0;
  int compares = 0;
  gpb_bank gpb_bank_i (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .alt_oe(alt_oe), .alt_out(alt_out), .alt_in(alt_in),
    .core_int_masked(core_int_masked), .vec_fetch(vec_fetch), .ext_irq(ext_irq),
    .wake(wake), .irq(irq));
  gpb_pad_model gpb_pad_model_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // Clock at 200 MHz
  initial begin
    forever #2.5 clock = ~clock;
  end
  // Counts and reports one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pad or flag comparison
  task automatic pchk(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    do @(posedge clock); while (waitrequest !== 1'h0);
    q = readdata;
    write <= 1'h0;
    read <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'h0, a, 8'h00);
    chk(q, {24'h0, exp});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  // Prints the counts and the verdict, then stops
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    wt(20000);
    bad_count++;
    report_and_stop;
  end
  // Test sequence
  initial begin
    wt(16);
    rst <= 1'h0;
    foreach (adr[i]) rdc(adr[i], 8'h00);
    tend("reset");
    ext_val <= '1;
    for (int i = 0; i < 9; i++) begin
      if (i % 3 != 0) begin
        wr(adr[i], 8'h5a ^ adr[i]);
        rdc(adr[i], 8'h5a ^ adr[i]);
        wr(adr[i], 8'h00);
      end
    end
    wr(8'h3c, 8'h77);
    rdc(8'h3c, 8'h00);
    byteenable <= 4'h0;
    wr(8'h14, 8'hff);
    byteenable <= 4'hf;
    rdc(8'h14, 8'h00);
    tend("access");
    alt_oe <= 24'h000140;
    alt_out <= 24'h000140;
    ext_val[7:0] <= 8'h00;
    wt(4);
    rdc(8'h20, 8'h40);
    pchk(pin_oe[15:8], 8'h01);
    pchk(pin_oe[7:0], 8'h00);
    alt_oe <= '0;
    ext_val[7:0] <= 8'hff;
    tend("alternate");
    ext_val[15:8] <= 8'h3c;
    wr(8'h10, 8'h5a);
    wt(4);
    rdc(8'h10, 8'h3c);
    wr(8'h14, 8'h0f);
    rdc(8'h10, 8'h3a);
    wr(8'h14, 8'hff);
    rdc(8'h10, 8'h5a);
    pchk(alt_in[15:8], 8'h5a);
    wr(8'h14, 8'h00);
    ext_val[15:8] <= 8'hff;
    tend("data");
    wr(8'h00, 8'h55);
    wr(8'h08, 8'h0f);
    wr(8'h04, 8'hff);
    wt(2);
    pchk(pin_oe[23:16], 8'haf);
    pchk(pin_out[23:16], 8'h05);
    pchk(pin_pullup[23:16], 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'hff);
    wt(2);
    ext_en[23:16] <= 8'h00;
    wt(4);
    rdc(8'h00, 8'hff);
    ext_en <= '1;
    wr(8'h08, 8'h00);
    tend("modes");
    wr(8'h28, 8'hff);
    wt(2);
    pchk(pin_pullup[7:0], 8'haf);
    wr(8'h20, 8'hff);
    wr(8'h24, 8'hff);
    wt(2);
    pchk(pin_oe[7:0], 8'haf);
    pchk(pin_out[7:0], 8'haf);
    wr(8'h20, 8'h00);
    wt(2);
    pchk(pin_oe[7:0], 8'hff);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h00);
    tend("open_drain");
    wr(8'h08, 8'h01);
    ext_val[16] <= 1'h0;
    for (int n = 0; n < 10 && ext_irq[1] !== 1'h1; n++) wt(1);
    pchk({6'h0, ext_irq}, 8'h02);
    pchk({7'h0, wake}, 8'h01);
    wr(8'h44, 8'h02);
    wt(2);
    pchk({7'h0, irq}, 8'h01);
    rdc(8'h40, 8'h02);
    vec_fetch <= 2'h2;
    wt(1);
    vec_fetch <= 2'h0;
    wt(2);
    pchk({6'h0, ext_irq, wake}, 8'h00);
    wr(8'h48, 8'h02);
    wt(2);
    pchk({7'h0, irq}, 8'h00);
    rdc(8'h40, 8'h00);
    core_int_masked <= 1'h1;
    ext_val[16] <= 1'h1;
    wt(6);
    ext_val[16] <= 1'h0;
    wt(6);
    pchk({6'h0, ext_irq, wake}, 8'h01);
    tend("interrupt");
    report_and_stop;
  end
endmodule
bind gpb_bank gpb_bank_properties gpb_bank_properties_i (.clock(clock), .rst(rst),
  .read(read), .write(write), .waitrequest(waitrequest), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_pullup(pin_pullup), .alt_oe(alt_oe), .alt_out(alt_out),
  .core_int_masked(core_int_masked), .vec_fetch(vec_fetch), .ext_irq(ext_irq),
  .wake(wake), .irq(irq));
`default_nettype wire
